// *** adc_sequence_control.v ***
/*
  Sequencing logic of the analog-to-digital converter: control registers,
  sequence length, result placement, external trigger, freeze and interrupt.
  Assumes the analog converter sits on mclk, takes conv_start pulses, honours
  conv_hold and conv_abort, and answers with conv_done and conv_result.
*/
// Behaviour
// - Enabled sequence-complete flag raises interrupt request
// - Interrupt flag mirrors status flag when enabled
// - Interrupt flag reads zero when disabled; unwritable
// - Level/edge and polarity select trigger sensitivity
// - Sequence register write aborts, starts nothing
// - Length code zero or top bit gives eight
// - Reset sets default sequence length four
// - Non-FIFO: nth result to nth register
// - FIFO: counter kept across sequence boundaries
// - FIFO counter wraps after last register
// - Status shows the result position counter
// - Abort or register start clears counter
// - Freeze field selects breakpoint response
// - Interrupt register write aborts, starts nothing
// - Trigger enable bit gates external trigger
`include "seq_consts.vh"

module adc_sequence_control (
  // Clock and reset
  input  wire       mclk,
  input  wire       rst,
  // Register port
  input  wire [7:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr,
  input  wire       rd,
  output reg  [7:0] rdata,
  // Analog converter handshake
  output wire       conv_start,
  output wire       conv_hold,
  output reg        conv_abort,
  input  wire       conv_done,
  input  wire [9:0] conv_result,
  // Result register file write port
  output reg        res_we,
  output reg  [2:0] res_index,
  output reg  [9:0] res_data,
  // External trigger pin and debug freeze
  input  wire       trig_pin,
  input  wire       freeze_req,
  // Interrupt
  output wire       irq
);

  // Control registers
  reg  [7:0] itc_r;
  reg  [7:0] sfc_r;
  reg        scan_r;
  reg  [`EV_W-1:0] ev_stat_r;
  reg  [`EV_W-1:0] ev_en_r;
  // Sequencer
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [3:0] conv_num_r;
  reg  [2:0] cc_r;
  reg        lvl_run_r;

  wire       trig_event;
  wire       trig_active;
  wire [3:0] seq_len;
  wire       fifo_mode;
  wire [1:0] frz_sel;
  wire       frz_finish;
  wire       frz_now;
  wire       wr_itc;
  wire       wr_sfc;
  wire       wr_start;
  wire       wr_clr;
  wire       aborting;
  wire       busy;
  wire       last_conv;
  wire       accept_done;
  wire       trig_start;
  wire       trig_busy;
  wire       seq_end;
  wire       restart;
  wire       seq_done_status_flag;
  wire [`EV_W-1:0] ev_set;
  wire       wr_irq_en;
  wire       cut_run;
  wire       idle_start;

  // Conversions per sequence for a four-bit length code
  function [3:0] len_decode;
    input [3:0] code;
    begin
      if (code[3] || code[2:0] == 3'h0)
        len_decode = 4'h8;
      else
        len_decode = {1'b0, code[2:0]};
    end
  endfunction

  // Register address match, shared by every write decode
  function addr_hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      addr_hit = (a == ofs);
    end
  endfunction

  // Next result slot; the three-bit width makes the wrap past the last
  // slot free, which FIFO placement relies on
  function [2:0] slot_next;
    input [2:0] slot;
    begin
      slot_next = slot + 3'h1;
    end
  endfunction

  // Next conversion number within a sequence
  function [3:0] count_next;
    input [3:0] num;
    begin
      count_next = num + 4'h1;
    end
  endfunction

  // Freeze code match for one selection
  function frz_is;
    input [1:0] sel;
    input [1:0] code;
    begin
      frz_is = (sel == code);
    end
  endfunction

  trigger_detect u_trig (
    .mclk        (mclk),
    .rst         (rst),
    .trig_pin    (trig_pin),
    .level_edge  (itc_r[`ITC_LEVEL_EDGE]),
    .polarity    (itc_r[`ITC_POLARITY]),
    .trig_event  (trig_event),
    .trig_active (trig_active)
  );

  // Field decode
  assign seq_len    = len_decode(sfc_r[`SFC_LEN_HI:`SFC_LEN_LO]);
  assign fifo_mode  = sfc_r[`SFC_FIFO];
  assign frz_sel    = sfc_r[`SFC_FRZ_HI:`SFC_FRZ_LO];
  // Freeze acts only while the debug logic holds its request
  assign frz_finish = freeze_req & frz_is(frz_sel, `FRZ_FINISH);
  assign frz_now    = freeze_req & frz_is(frz_sel, `FRZ_NOW);

  // Write decode
  assign wr_itc    = wr & addr_hit(addr, `OFS_ITC);
  assign wr_sfc    = wr & addr_hit(addr, `OFS_SFC);
  assign wr_start  = wr & addr_hit(addr, `OFS_START);
  assign wr_clr    = wr & addr_hit(addr, `OFS_IRQ_CLR);
  assign wr_irq_en = wr & addr_hit(addr, `OFS_IRQ_EN);
  // Control writes abort without starting; a start write also cuts the old run
  assign aborting  = wr_itc | wr_sfc;
  assign busy      = (state_r != `ST_IDLE);
  // Any of these writes ends the run in progress and clears the counters
  assign cut_run    = aborting | wr_start;
  // A trigger may open a sequence only from idle; later edges are overruns
  assign idle_start = trig_start & ~busy;

  // A result is taken only while not frozen at once, so a held conversion
  // cannot slip its result into the file mid-freeze
  assign accept_done = (state_r == `ST_WAIT) & conv_done & ~frz_now;
  assign last_conv   = (count_next(conv_num_r) == seq_len);
  assign seq_end     = accept_done & last_conv;

  // Trigger starts count only with the enable bit and no control or start write
  assign trig_start = itc_r[`ITC_TRIG_EN] & ~aborting & ~wr_start &
                      (trig_event | (trig_active & ~busy));
  assign trig_busy  = trig_start & trig_event & busy & ~seq_end;
  // Back-to-back sequences for scan mode or a held level trigger
  assign restart    = seq_end & (scan_r | (lvl_run_r & trig_active));

  // Sticky events; set beats clear when both land together
  assign ev_set = {trig_busy, aborting & busy, seq_end};
  assign seq_done_status_flag    = ev_stat_r[`EV_SEQ_DONE];

  // Interrupt level from enabled sticky events
  assign irq = |(ev_stat_r & ev_en_r);

  // Converter strobes
  assign conv_start = (state_r == `ST_ISSUE) & ~frz_finish & ~frz_now;
  assign conv_hold  = (state_r == `ST_WAIT) & frz_now;

  // Sequencer next state
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `ST_IDLE: begin
        if (wr_start || idle_start)
          state_nxt = `ST_ISSUE;
      end
      `ST_ISSUE: begin
        if (conv_start)
          state_nxt = `ST_WAIT;
      end
      `ST_WAIT: begin
        if (accept_done) begin
          if (!last_conv || restart)
            state_nxt = `ST_ISSUE;
          else
            state_nxt = `ST_IDLE;
        end
      end
      default: state_nxt = `ST_IDLE;
    endcase
    // Control and start writes override whatever the sequencer planned
    if (aborting)
      state_nxt = `ST_IDLE;
    else if (wr_start)
      state_nxt = `ST_ISSUE;
  end

  // Sequencer state, conversion number and result position
  always @(posedge mclk) begin
    if (rst) begin
      state_r    <= `ST_IDLE;
      conv_num_r <= 4'h0;
      cc_r       <= 3'h0;
      lvl_run_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      if (cut_run) begin
        conv_num_r <= 4'h0;
        cc_r       <= 3'h0;
        lvl_run_r  <= 1'b0;
      end else if (idle_start) begin
        // Non-FIFO trigger runs restart placement at slot zero
        conv_num_r <= 4'h0;
        lvl_run_r  <= ~itc_r[`ITC_LEVEL_EDGE] ? 1'b0 : 1'b1;
        if (!fifo_mode)
          cc_r <= 3'h0;
      end else if (accept_done) begin
        if (last_conv) begin
          conv_num_r <= 4'h0;
          // FIFO keeps counting across sequences, wrapping past the last slot
          if (fifo_mode)
            cc_r <= slot_next(cc_r);
          else
            cc_r <= 3'h0;
        end else begin
          conv_num_r <= count_next(conv_num_r);
          cc_r       <= slot_next(cc_r);
        end
      end
    end
  end

  // Result write port: slot follows the position counter
  always @(posedge mclk) begin
    if (rst) begin
      res_we    <= 1'b0;
      res_index <= 3'h0;
      res_data  <= 10'h000;
    end else begin
      res_we <= accept_done;
      if (accept_done) begin
        res_index <= cc_r;
        res_data  <= conv_result;
      end
    end
  end

  // Abort pulse tells the converter to drop its current conversion
  always @(posedge mclk) begin
    if (rst)
      conv_abort <= 1'b0;
    else
      conv_abort <= cut_run & busy;
  end

  // Control registers; the flag bit of the interrupt register is not stored
  always @(posedge mclk) begin
    if (rst) begin
      itc_r   <= `ITC_RESET;
      sfc_r   <= `SFC_RESET;
      scan_r  <= 1'b0;
      ev_en_r <= {`EV_W{1'b0}};
    end else begin
      if (wr_itc) begin
        itc_r <= {wdata[7:1], 1'b0};
      end else if (wr_irq_en) begin
        itc_r[`ITC_IRQ_EN] <= wdata[`EV_SEQ_DONE];
      end
      if (wr_sfc)
        sfc_r <= wdata & `SFC_WMASK;
      if (wr_start)
        scan_r <= wdata[`START_SCAN];
      // The enable lives in two flops kept in step, so either register
      // reads back what the other one wrote
      if (wr_irq_en)
        ev_en_r <= wdata[`EV_W-1:0];
      else if (wr_itc)
        ev_en_r[`EV_SEQ_DONE] <= wdata[`ITC_IRQ_EN];
    end
  end

  // Sticky event status; a start register write also clears sequence done
  always @(posedge mclk) begin
    if (rst) begin
      ev_stat_r <= {`EV_W{1'b0}};
    end else begin
      ev_stat_r <= ev_set |
                   (ev_stat_r & ~(wr_clr ? wdata[`EV_W-1:0] : {`EV_W{1'b0}})
                    & ~{{(`EV_W-1){1'b0}}, wr_start});
    end
  end

  // Registered read data, valid in the cycle after the strobe
  always @(posedge mclk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        `OFS_ITC:
          // Flag mirrors status only while its enable is set
          rdata <= {itc_r[7:1], itc_r[`ITC_IRQ_EN] & seq_done_status_flag};
        `OFS_SFC:
          rdata <= sfc_r;
        `OFS_START:
          rdata <= {2'h0, scan_r, 5'h00};
        `OFS_STATUS:
          rdata <= {seq_done_status_flag, busy, 3'h0, cc_r};
        `OFS_IRQ_STAT:
          rdata <= {5'h00, ev_stat_r};
        `OFS_IRQ_EN:
          rdata <= {5'h00, ev_en_r};
        default:
          rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // The reserved freeze code behaves as continue: it matches neither
  // freeze decode above, so no extra logic is spent on it.
  // Software is expected to pair FIFO placement with scan or trigger runs
  // and track valid slots by the per-result complete flags downstream.

endmodule

// *** adc_sequence_control_monitor.sv ***
/*
  Port checker for the converter sequencing block.
  Assumes a bind onto adc_sequence_control, one clock mclk.
*/
module seq_ctl_monitor (
  // Clock and reset
  input wire logic       mclk,
  input wire logic       rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  // Converter and results
  input wire logic       conv_start,
  input wire logic       conv_hold,
  input wire logic       conv_abort,
  input wire logic       conv_done,
  input wire logic [9:0] conv_result,
  input wire logic       res_we,
  input wire logic [9:0] res_data,
  // Debug and interrupt
  input wire logic       freeze_req,
  input wire logic       irq
);
  // One domain; checks other than reset_quiet_a rest while reset is high
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  reset_quiet_a: assert property (disable iff (1'b0)
    rst |=> rdata == 8'h00 && !conv_abort && !res_we && !irq) else $error("reset left outputs");
  read_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata without read");
  start_pulse_a: assert property (conv_start |=> !conv_start) else $error("start too long");
  done_write_a: assert property (
    res_we |-> $past(conv_done) && res_data == $past(conv_result)) else $error("bad result write");
  hold_freeze_a: assert property (
    conv_hold |-> freeze_req || $past(freeze_req)) else $error("hold without freeze");
  hold_ignore_a: assert property (
    conv_done && conv_hold |=> !res_we) else $error("done taken while held");
  ctl_write_a: assert property (
    wr && (addr == 8'h02 || addr == 8'h03) |=> !conv_start) else $error("control write started");
  flag_gate_a: assert property (
    rd && addr == 8'h02 |=> !rdata[0] || rdata[1]) else $error("flag set while disabled");
  abort_pulse_a: assert property (conv_abort |=> !conv_abort) else $error("abort too long");
endmodule

bind adc_sequence_control seq_ctl_monitor mon (
  .mclk, .rst, .addr, .wr, .rd, .rdata, .conv_start, .conv_hold, .conv_abort,
  .conv_done, .conv_result, .res_we, .res_data, .freeze_req, .irq
);

// *** adc_sequence_control_tb.sv ***
/*
  Self-checking bench for the converter sequencing block.
  Assumes the offsets of seq_consts.vh; the bench plays host and converter.
*/
`include "seq_consts.vh"

module adc_sequence_control_tb;
  timeunit 1ns;
  timeprecision 1ns;

  // Stimulus
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        conv_done = 1'b0;
  logic        trig_pin = 1'b0;
  logic        freeze_req = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [7:0]  wdata = 8'h00;
  logic [9:0]  conv_result = 10'h000;
  // Design outputs
  wire  [7:0]  rdata;
  wire  [2:0]  res_index;
  wire  [9:0]  res_data;
  wire         conv_start;
  wire         conv_hold;
  wire         conv_abort;
  wire         res_we;
  wire         irq;
  // Expected-result notes and counters
  logic [15:0] rd_q[$];
  logic [12:0] res_q[$];
  logic [15:0] m;
  logic        rd_d = 1'b0;
  logic [2:0]  cc;
  logic [3:0]  codes[5] = '{4'h0, 4'h1, 4'h7, 4'hC, 4'h5};
  int          err_count = 0;
  int          total_checks = 0;

  always #50 mclk = ~mclk;

  adc_sequence_control DUT (
    .mclk, .rst, .addr, .wdata, .wr, .rd, .rdata, .conv_start, .conv_hold, .conv_abort,
    .conv_done, .conv_result, .res_we, .res_index, .res_data, .trig_pin, .freeze_req, .irq
  );

  task automatic chk(input logic [12:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask

  // Strobes keep a gap cycle so no signal is driven twice in one step
  task automatic wreg(input logic [7:0] a, d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rreg(input logic [7:0] a, e, k = 8'hFF);
    rd_q.push_back({k, e & k});
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_start();
    for (int n = 0; n < 40 && conv_start !== 1'b1; n++)
      @(posedge mclk);
    chk(conv_start, 1'b1);
  endtask

  // Converter answer after a random wait; the data line then shows junk
  task automatic deliver(input logic [2:0] idx);
    logic [9:0] d;
    d = 10'($urandom);
    repeat (1 + $urandom % 3) @(posedge mclk);
    res_q.push_back({idx, d});
    conv_done <= 1'b1;
    conv_result <= d;
    @(posedge mclk);
    conv_done <= 1'b0;
    conv_result <= ~d;
  endtask

  task automatic conv1(input logic [2:0] idx);
    wait_start();
    deliver(idx);
  endtask

  task automatic run_seq(input logic [7:0] sfc, input int n, input logic [7:0] go);
    wreg(`OFS_SFC, sfc);
    wreg(`OFS_START, go);
    for (int i = 0; i < n; i++) begin
      conv1(cc);
      cc = cc + 3'h1;
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Results are matched against the oldest note of their kind
  always @(posedge mclk) begin
    rd_d <= rd;
    if (rd_d) begin
      m = rd_q.pop_front();
      chk(rdata & m[15:8], m[7:0]);
    end
    if (res_we)
      chk({res_index, res_data}, res_q.size() > 0 ? res_q.pop_front() : 13'hX);
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #2000000;
    err_count++;
    give_verdict();
  end

  initial begin
    void'($urandom(32'h1DB04E1A));
    codes[4] = 4'($urandom);
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    rreg(`OFS_ITC, 8'h00);
    rreg(`OFS_SFC, 8'h20);
    rreg(8'h7F, 8'h00);
    $display("reset test done");
    // Length codes in fixed placement, then no further start
    foreach (codes[i]) begin
      cc = 3'h0;
      run_seq({1'b0, codes[i], 3'h0}, (codes[i][3] || codes[i] == 4'h0) ? 8 : codes[i], 8'h00);
      repeat (6) @(posedge mclk);
      chk(conv_start, 1'b0);
      rreg(`OFS_STATUS, 8'h80, 8'hC0);
    end
    $display("length test done");
    // Sequence flag is masked, enabled, mirrored and cleared
    chk(irq, 1'b0);
    wreg(`OFS_ITC, 8'h01);
    rreg(`OFS_ITC, 8'h00, 8'h03);
    wreg(`OFS_IRQ_EN, 8'h01);
    chk(irq, 1'b1);
    rreg(`OFS_ITC, 8'h03, 8'h03);
    wreg(`OFS_ITC, 8'h02);
    rreg(`OFS_ITC, 8'h03, 8'h03);
    wreg(`OFS_IRQ_CLR, 8'h01);
    chk(irq, 1'b0);
    rreg(`OFS_IRQ_STAT, 8'h00, 8'h01);
    wreg(`OFS_IRQ_EN, 8'h00);
    $display("interrupt test done");
    // Each sensitivity code: ignored while disabled, starts when enabled
    for (int c = 0; c < 4; c++) begin
      trig_pin <= ~c[0];
      wreg(`OFS_ITC, {3'h0, 2'(c), 3'h0});
      rreg(`OFS_ITC, {3'h0, 2'(c), 3'h0});
      trig_pin <= c[0];
      repeat (8) @(posedge mclk);
      chk(conv_start, 1'b0);
      trig_pin <= ~c[0];
      repeat (4) @(posedge mclk);
      wreg(`OFS_ITC, {3'h0, 2'(c), 3'h4});
      trig_pin <= c[0];
      wait_start();
      wreg(`OFS_ITC, 8'h00);
      chk(conv_abort, 1'b1);
    end
    $display("trigger test done");
    // FIFO scan runs the counter on through a wrap
    cc = 3'h0;
    run_seq(8'h1C, 9, 8'h20);
    wait_start();
    rreg(`OFS_STATUS, 8'h41, 8'h47);
    wreg(`OFS_SFC, 8'h1C);
    chk(conv_abort, 1'b1);
    rreg(`OFS_STATUS, 8'h00, 8'h47);
    cc = 3'h0;
    run_seq(8'h1C, 3, 8'h00);
    $display("fifo test done");
    // Freeze codes with the debug request raised mid-conversion
    for (int f = 0; f < 4; f++) begin
      cc = 3'h0;
      run_seq({1'b0, 4'h2, 1'b0, 2'(f)}, 0, 8'h00);
      wait_start();
      freeze_req <= 1'b1;
      repeat (2) @(posedge mclk);
      chk(conv_hold, f == 3);
      if (f == 3) begin
        conv_done <= 1'b1;
        @(posedge mclk);
        conv_done <= 1'b0;
      end
      freeze_req <= (f != 3);
      deliver(3'h0);
      if (f == 2) begin
        repeat (6) @(posedge mclk);
        chk(conv_start, 1'b0);
      end
      freeze_req <= 1'b0;
      conv1(3'h1);
    end
    $display("freeze test done");
    give_verdict();
  end
endmodule

// *** seq_consts.vh ***
/*
  Register offsets, field positions, reset values and state codes
  of the converter sequencing block.
  Assumes inclusion by bare name from the design files and the bench.
*/
`ifndef SEQ_CONSTS_VH
`define SEQ_CONSTS_VH

// Register offsets on the plain register port
`define OFS_ITC        8'h02
`define OFS_SFC        8'h03
`define OFS_START      8'h05
`define OFS_STATUS     8'h06
`define OFS_IRQ_STAT   8'h08
`define OFS_IRQ_CLR    8'h09
`define OFS_IRQ_EN     8'h0A

// Interrupt/trigger control fields
`define ITC_LEVEL_EDGE 4
`define ITC_POLARITY   3
`define ITC_TRIG_EN    2
`define ITC_IRQ_EN     1
`define ITC_IRQ_FLAG   0
`define ITC_RESET      8'h00

// Sequence/FIFO/freeze control fields
`define SFC_LEN_HI     6
`define SFC_LEN_LO     3
`define SFC_FIFO       2
`define SFC_FRZ_HI     1
`define SFC_FRZ_LO     0
`define SFC_RESET      8'h20
`define SFC_WMASK      8'h7F

// Start register and status register fields
`define START_SCAN     5
`define STAT_SCF       7
`define STAT_BUSY      6

// Sticky event bits
`define EV_SEQ_DONE    0
`define EV_ABORT       1
`define EV_OVERRUN     2
`define EV_W           3

// Freeze selections
`define FRZ_CONTINUE   2'h0
`define FRZ_RESERVED   2'h1
`define FRZ_FINISH     2'h2
`define FRZ_NOW        2'h3

// Sequencer state codes
`define ST_IDLE        2'h0
`define ST_ISSUE       2'h1
`define ST_WAIT        2'h2

`endif

// *** trigger_detect.v ***
/*
  External trigger synchroniser and sensitivity decoder.
  Assumes the trigger pin is asynchronous to mclk.
*/
`include "seq_consts.vh"

module trigger_detect (
  // Clock and reset
  input  wire mclk,
  input  wire rst,
  // Trigger pin
  input  wire trig_pin,
  // Sensitivity selection
  input  wire level_edge,
  input  wire polarity,
  // Decoded trigger
  output reg  trig_event,
  output reg  trig_active
);

  reg sync1_r;
  reg sync2_r;
  reg prev_r;

  // Two-stage synchroniser, then one stage of history for edges
  always @(posedge mclk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      prev_r  <= 1'b0;
    end else begin
      sync1_r <= trig_pin;
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  // Edge codes pulse once; level codes hold while the pin sits at the level
  always @* begin
    trig_active = 1'b0;
    trig_event  = 1'b0;
    case ({level_edge, polarity})
      2'h0: trig_event = prev_r & ~sync2_r;
      2'h1: trig_event = ~prev_r & sync2_r;
      2'h2: trig_active = ~sync2_r;
      2'h3: trig_active = sync2_r;
      default: trig_event = 1'b0;
    endcase
  end

endmodule
